/* File: common/dttr_defines.vh */
// Constants for the trigger and timing router: selector codes and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef DTTR_DEFINES_VH
`define DTTR_DEFINES_VH

// Analog trigger conditions
`define DTTR_ACOND_BELOW_LOW   3'h0
`define DTTR_ACOND_ABOVE_HIGH  3'h1
`define DTTR_ACOND_INSIDE      3'h2
`define DTTR_ACOND_HIGH_HYST   3'h3
`define DTTR_ACOND_LOW_HYST    3'h4
// Offset-binary level codes
`define DTTR_LEVEL_ZERO        8'h80
`define DTTR_LEVEL_TOP         8'hff
`define DTTR_LEVEL_BOTTOM      8'h01
// Timebase sources
`define DTTR_TB_INTERNAL       2'h0
`define DTTR_TB_EXTERNAL       2'h1
`define DTTR_TB_SYNCBUS        2'h2
// Trigger sources (converter and output paths)
`define DTTR_TRIG_SOFTWARE     2'h0
`define DTTR_TRIG_DIGITAL      2'h1
`define DTTR_TRIG_ANALOG       2'h2
`define DTTR_TRIG_SYNCBUS      2'h3
// Scan start, conversion and update strobe sources
`define DTTR_STRB_INTERNAL     2'h0
`define DTTR_STRB_AUX          2'h1
`define DTTR_STRB_SYNCBUS      2'h2
// Reset values: every selector on its internal source
`define DTTR_RST_ACOND         3'h0
`define DTTR_RST_SEL           2'h0
// Timing
`define DTTR_CLK_PERIOD_NS     25
`define DTTR_MIN_PULSE_NS      20

`endif

/* File: verilog/dttr_edge_sync.v */
// Two-flop synchroniser with edge detector, one pulse per selected edge.
// Assumes an asynchronous level input and the single system clock.
`timescale 1ns/10ps
module dttr_edge_sync (
	input  wire sys_clk_i,
	input  wire rst_b_i,
	input  wire async_i,
	input  wire falling_i,
	output reg  level_o,
	output reg  pulse_o
);
	reg meta_reg;
	reg prev_reg;

	// First flop feeds only the second; edge logic sees settled copies only
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			meta_reg <= 1'b0;
			level_o  <= 1'b0;
			prev_reg <= 1'b0;
			pulse_o  <= 1'b0;
		end else begin
			meta_reg <= async_i;
			level_o  <= meta_reg;
			prev_reg <= level_o;
			pulse_o  <= falling_i ? (prev_reg & ~level_o) : (~prev_reg & level_o);
		end
	end
endmodule

/* File: verilog/dttr_router.v */
// Trigger and timing-signal router: analog trigger conditions, digital trigger
// edges and source multiplexers for timebase, triggers, scan and strobes.
// Assumes sys_clk_i is the master timebase chosen outside from tb_sel_o,
// comparator results arrive as level codes, and all pins are asynchronous.
// Limitation: a pin level must last about one timebase period to be seen; shorter
// pulses may be lost, the price of a plain two-flop synchroniser with no pulse catcher.
// Summary of operation
// R1: Level codes are offset binary: 0x80 zero, 0xff top, 0x01 bottom.
// R2: Five analog trigger conditions built from lower and upper thresholds.
// R3: Below-low fires while input is under the lower threshold.
// R4: Above-high fires while input exceeds the upper threshold.
// R5: Inside-region fires while input lies between both thresholds.
// R6: Software must program upper threshold above lower for windowed conditions.
// R7: High-hysteresis fires rising above upper; lower threshold governs re-arm.
// R8: Low-hysteresis fires falling below lower; upper threshold governs re-arm.
// R9: Digital triggers fire on selected edge, separate converter and output inputs.
// R10: External pulses and strobes last at least 20 ns.
// R11: Timebase selected from internal, external or sync-bus source.
// R12: External timebase stays between 1 MHz and 40 MHz.
// R13: Converter trigger from digital, analog, software or sync-bus source.
// R14: Scan start from internal counter, aux input zero or sync bus.
// R15: Selected scan start stays synchronous to the master timebase.
// R16: Conversion strobe from counter, aux zero or bus; one per rising edge.
// R17: Output trigger from digital, analog, software or sync-bus source.
// R18: Update strobe from counter, aux one or bus; one per rising edge.
// R19: Reset returns every selection to its internal source.
// R20: Aux-zero conversion ignores scan counter, scan start and trigger settings.
// R21: Trigger echo outputs follow the selected source of each path.
// R22: External inputs are synchronised and delivered as one-cycle pulses.
// R23: A hysteresis trigger re-fires only after crossing the opposite threshold.
`timescale 1ns/10ps
`include "dttr_defines.vh"
module dttr_router #(
	parameter LEVEL_W = 8
) (
	input  wire               sys_clk_i,
	input  wire               rst_b_i,
	// Analog trigger
	input  wire [LEVEL_W-1:0] trig_level_code_i,
	input  wire [LEVEL_W-1:0] low_threshold_i,
	input  wire [LEVEL_W-1:0] high_threshold_i,
	input  wire [2:0]         analog_cond_i,
	// Digital trigger pins and polarity
	input  wire               adc_digital_trig_in_i,
	input  wire               dac_digital_trig_in_i,
	input  wire               adc_trig_falling_i,
	input  wire               dac_trig_falling_i,
	// Auxiliary inputs and sync bus
	input  wire               aux_input_zero_i,
	input  wire               aux_input_one_i,
	input  wire               syncbus_adc_trigger_i,
	input  wire               syncbus_dac_trigger_i,
	input  wire               syncbus_scan_begin_i,
	input  wire               syncbus_convert_strobe_i,
	input  wire               syncbus_dac_update_i,
	// Internal sources on the same clock
	input  wire               sw_adc_trig_i,
	input  wire               sw_dac_trig_i,
	input  wire               scan_count_start_i,
	input  wire               conv_count_strobe_i,
	input  wire               update_count_strobe_i,
	// Selections
	input  wire [1:0]         tb_sel_i,
	input  wire [1:0]         adc_trig_sel_i,
	input  wire [1:0]         dac_trig_sel_i,
	input  wire [1:0]         scan_sel_i,
	input  wire [1:0]         conv_sel_i,
	input  wire [1:0]         update_sel_i,
	input  wire               sel_load_i,
	// Results
	output reg  [1:0]         tb_sel_o,
	output reg                analog_trig_o,
	output reg                adc_trigger_o,
	output reg                dac_trigger_o,
	output reg                adc_trigger_echo_o,
	output reg                dac_trigger_echo_o,
	output reg                scan_start_o,
	output reg                convert_strobe_o,
	output reg                dac_update_strobe_o,
	output reg                aux_conv_mode_o
);
	localparam N_IN = 7;

	// Slots of the synchroniser bank, so the multiplexers name what they pick
	localparam PIN_ADC_DTRIG = 0;
	localparam PIN_DAC_DTRIG = 1;
	localparam PIN_AUX_ZERO  = 2;
	localparam PIN_AUX_ONE   = 3;
	localparam PIN_BUS_ADC   = 4;
	localparam PIN_BUS_DAC   = 5;
	localparam PIN_BUS_SCAN  = 6;

	// Held selections
	reg [1:0] adc_sel_reg;
	reg [1:0] dac_sel_reg;
	reg [1:0] scan_sel_reg;
	reg [1:0] conv_sel_reg;
	reg [1:0] upd_sel_reg;
	reg [2:0] cond_reg;
	reg       armed_reg;
	reg       acond_reg;

	wire [N_IN-1:0] pin_raw;
	wire [N_IN-1:0] pin_fall;
	wire [N_IN-1:0] pin_lvl;
	wire [N_IN-1:0] pin_pulse;

	// Pin order: 0 adc dtrig, 1 dac dtrig, 2 aux0, 3 aux1, 4 bus adc trig,
	// 5 bus dac trig, 6 bus scan begin; bus strobes get their own synchronisers below
	assign pin_raw  = {syncbus_scan_begin_i, syncbus_dac_trigger_i, syncbus_adc_trigger_i,
		aux_input_one_i, aux_input_zero_i, dac_digital_trig_in_i, adc_digital_trig_in_i};
	assign pin_fall = {5'h00, dac_trig_falling_i, adc_trig_falling_i};

	// Every external input passes two flops, then an edge detector [R22] [R9]
	genvar gi;
	generate
		for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_pin
			dttr_edge_sync u_sync (
				.sys_clk_i (sys_clk_i),
				.rst_b_i   (rst_b_i),
				.async_i   (pin_raw[gi]),
				.falling_i (pin_fall[gi]),
				.level_o   (pin_lvl[gi]),
				.pulse_o   (pin_pulse[gi])
			);
		end
	endgenerate

	wire bus_conv_lvl;
	wire bus_conv_pulse;
	wire bus_upd_lvl;
	wire bus_upd_pulse;

	// Sync-bus strobes are edge-sensitive too, rising only
	dttr_edge_sync u_bus_conv (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.async_i   (syncbus_convert_strobe_i),
		.falling_i (1'b0),
		.level_o   (bus_conv_lvl),
		.pulse_o   (bus_conv_pulse)
	);

	dttr_edge_sync u_bus_upd (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.async_i   (syncbus_dac_update_i),
		.falling_i (1'b0),
		.level_o   (bus_upd_lvl),
		.pulse_o   (bus_upd_pulse)
	);

	// Selections load on request; reset puts all back on internal sources [R19]
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			tb_sel_o     <= `DTTR_RST_SEL;
			adc_sel_reg  <= `DTTR_RST_SEL;
			dac_sel_reg  <= `DTTR_RST_SEL;
			scan_sel_reg <= `DTTR_RST_SEL;
			conv_sel_reg <= `DTTR_RST_SEL;
			upd_sel_reg  <= `DTTR_RST_SEL;
			cond_reg     <= `DTTR_RST_ACOND;
		end else if (sel_load_i) begin
			// Unused timebase code falls back to the internal oscillator [R11]
			tb_sel_o     <= (tb_sel_i == 2'h3) ? `DTTR_TB_INTERNAL : tb_sel_i;
			adc_sel_reg  <= adc_trig_sel_i;
			dac_sel_reg  <= dac_trig_sel_i;
			scan_sel_reg <= scan_sel_i;
			conv_sel_reg <= conv_sel_i;
			upd_sel_reg  <= update_sel_i;
			cond_reg     <= analog_cond_i;
		end
	end

	// Offset-binary codes compare as plain unsigned numbers, 0x80 at zero [R1]
	wire below_low  = trig_level_code_i < low_threshold_i;
	wire above_high = trig_level_code_i > high_threshold_i;

	// Analog condition evaluation [R2]
	reg acond_next;
	reg armed_next;
	always @* begin
		acond_next = 1'b0;
		armed_next = armed_reg;
		case (cond_reg)
			`DTTR_ACOND_BELOW_LOW:  acond_next = below_low;               // [R3]
			`DTTR_ACOND_ABOVE_HIGH: acond_next = above_high;              // [R4]
			`DTTR_ACOND_INSIDE:     acond_next = !below_low && !above_high; // [R5]
			`DTTR_ACOND_HIGH_HYST: begin
				// Fire above upper, re-arm only once back under lower [R7] [R23]
				if (armed_reg && above_high) begin
					acond_next = 1'b1;
					armed_next = 1'b0;
				end else if (below_low) begin
					armed_next = 1'b1;
				end
			end
			`DTTR_ACOND_LOW_HYST: begin
				// Fire under lower, re-arm only once back over upper [R8] [R23]
				if (armed_reg && below_low) begin
					acond_next = 1'b1;
					armed_next = 1'b0;
				end else if (above_high) begin
					armed_next = 1'b1;
				end
			end
			default: acond_next = 1'b0;
		endcase
	end

	// Analog trigger delivered as a rising-edge pulse of the condition
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			acond_reg     <= 1'b0;
			armed_reg     <= 1'b1;
			analog_trig_o <= 1'b0;
		end else begin
			acond_reg     <= acond_next;
			armed_reg     <= armed_next;
			analog_trig_o <= acond_next & ~acond_reg; // [R22]
		end
	end

	// Converter trigger source; trigger and echo share this one pick
	reg adc_trig_next;
	always @* begin
		case (adc_sel_reg) // [R13]
			`DTTR_TRIG_SOFTWARE: adc_trig_next = sw_adc_trig_i;
			`DTTR_TRIG_DIGITAL:  adc_trig_next = pin_pulse[PIN_ADC_DTRIG];
			`DTTR_TRIG_ANALOG:   adc_trig_next = analog_trig_o;
			default:             adc_trig_next = pin_pulse[PIN_BUS_ADC];
		endcase
	end

	// Output-path trigger source; both paths share the one analog trigger
	reg dac_trig_next;
	always @* begin
		case (dac_sel_reg) // [R17]
			`DTTR_TRIG_SOFTWARE: dac_trig_next = sw_dac_trig_i;
			`DTTR_TRIG_DIGITAL:  dac_trig_next = pin_pulse[PIN_DAC_DTRIG];
			`DTTR_TRIG_ANALOG:   dac_trig_next = analog_trig_o;
			default:             dac_trig_next = pin_pulse[PIN_BUS_DAC];
		endcase
	end

	// Aux zero as conversion strobe overrides scan timing and the converter trigger
	wire aux_conv = (conv_sel_reg == `DTTR_STRB_AUX);

	// Scan start source; aux zero here wants a pulse over one timebase period
	reg scan_next;
	always @* begin
		case (scan_sel_reg) // [R14]
			`DTTR_STRB_INTERNAL: scan_next = scan_count_start_i;
			`DTTR_STRB_AUX:      scan_next = pin_pulse[PIN_AUX_ZERO];
			`DTTR_STRB_SYNCBUS:  scan_next = pin_pulse[PIN_BUS_SCAN];
			default:             scan_next = scan_count_start_i;
		endcase
	end

	// Conversion strobe source; one pulse per rising edge of aux zero or bus
	reg conv_next;
	always @* begin
		case (conv_sel_reg) // [R16]
			`DTTR_STRB_INTERNAL: conv_next = conv_count_strobe_i;
			`DTTR_STRB_AUX:      conv_next = pin_pulse[PIN_AUX_ZERO];
			`DTTR_STRB_SYNCBUS:  conv_next = bus_conv_pulse;
			default:             conv_next = conv_count_strobe_i;
		endcase
	end

	// Update strobe source; one pulse per rising edge of aux one or bus
	reg upd_next;
	always @* begin
		case (upd_sel_reg) // [R18]
			`DTTR_STRB_INTERNAL: upd_next = update_count_strobe_i;
			`DTTR_STRB_AUX:      upd_next = pin_pulse[PIN_AUX_ONE];
			`DTTR_STRB_SYNCBUS:  upd_next = bus_upd_pulse;
			default:             upd_next = update_count_strobe_i;
		endcase
	end

	// Registered outputs; all timebase-synchronous, pin and analog sources as single pulses, internal sources passed on as driven
	always @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			adc_trigger_o       <= 1'b0;
			dac_trigger_o       <= 1'b0;
			adc_trigger_echo_o  <= 1'b0;
			dac_trigger_echo_o  <= 1'b0;
			scan_start_o        <= 1'b0;
			convert_strobe_o    <= 1'b0;
			dac_update_strobe_o <= 1'b0;
			aux_conv_mode_o     <= 1'b0;
		end else begin
			// In aux conversion mode the converter trigger and scan start are masked [R20]
			adc_trigger_o       <= adc_trig_next & ~aux_conv;
			dac_trigger_o       <= dac_trig_next;
			adc_trigger_echo_o  <= adc_trig_next; // [R21]
			dac_trigger_echo_o  <= dac_trig_next; // [R21]
			scan_start_o        <= scan_next & ~aux_conv; // [R15] [R20]
			convert_strobe_o    <= conv_next;
			dac_update_strobe_o <= upd_next;
			aux_conv_mode_o     <= aux_conv;
		end
	end
endmodule

/* File: tb/dttr_far_side.sv */
// Far-side model: trigger pins, aux inputs and peer-card sync-bus lines.
// Assumes fire_i is raised for one clock; each pin rests at its idle_i level.
`timescale 1ns/10ps
module dttr_far_side (
	input  wire       sys_clk_i,
	input  wire [8:0] fire_i,
	input  wire [8:0] idle_i,
	output reg  [8:0] pin_o = 9'h000
);
	reg [8:0] dly1_reg = 9'h000;
	reg [8:0] dly2_reg = 9'h000;
	// Pulse lasts three periods, well above the minimum width
	always @(posedge sys_clk_i) begin
		dly1_reg <= fire_i;
		dly2_reg <= dly1_reg;
		pin_o <= #2 idle_i ^ (fire_i | dly1_reg | dly2_reg);
	end
endmodule

/* File: tb/dttr_asserts.sv */
// Checker for the router: selections, masking, pulse shape, analog firing.
// Assumes a bind onto dttr_router with one clock and a synchronous reset.
`timescale 1ns/10ps
module dttr_asserts (
	input wire       sys_clk_i,
	input wire       rst_b_i,
	input wire [7:0] trig_level_code_i,
	input wire [7:0] low_threshold_i,
	input wire [7:0] high_threshold_i,
	input wire [2:0] analog_cond_i,
	input wire [1:0] tb_sel_i,
	input wire [1:0] conv_sel_i,
	input wire       sel_load_i,
	input wire [1:0] tb_sel_o,
	input wire       analog_trig_o,
	input wire       adc_trigger_o,
	input wire       adc_trigger_echo_o,
	input wire       scan_start_o,
	input wire       convert_strobe_o,
	input wire       aux_conv_mode_o
);
	reg  [2:0] cond_reg;
	wire       below = trig_level_code_i < low_threshold_i;
	wire       above = trig_level_code_i > high_threshold_i;
	wire       hit   = cond_reg == 3'h0 ? below : cond_reg == 3'h1 ? above : !below && !above;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// Shadow of the loaded condition, so a firing can be tied to the codes
	always @(posedge sys_clk_i) begin
		if (!rst_b_i)
			cond_reg <= 3'h0;
		else if (sel_load_i)
			cond_reg <= analog_cond_i;
	end
	property p_tb_load;
		sel_load_i |=> tb_sel_o == ($past(tb_sel_i) == 2'h3 ? 2'h0 : $past(tb_sel_i));
	endproperty
	a_tb_load: assert property (p_tb_load) else $error("timebase selection wrong");
	property p_reset;
		disable iff (1'b0) !rst_b_i |=> tb_sel_o == 2'h0 && !aux_conv_mode_o;
	endproperty
	a_reset: assert property (p_reset) else $error("selection kept over reset");
	property p_aux_mode;
		sel_load_i |-> ##2 aux_conv_mode_o == ($past(conv_sel_i, 2) == 2'h1);
	endproperty
	a_aux_mode: assert property (p_aux_mode) else $error("aux mode flag wrong");
	property p_mask;
		aux_conv_mode_o |-> !adc_trigger_o && !scan_start_o;
	endproperty
	a_mask: assert property (p_mask) else $error("trigger or scan in aux mode");
	property p_echo;
		adc_trigger_o |-> adc_trigger_echo_o;
	endproperty
	a_echo: assert property (p_echo) else $error("trigger without echo");
	property p_apulse;
		analog_trig_o |=> !analog_trig_o;
	endproperty
	a_apulse: assert property (p_apulse) else $error("analog pulse too long");
	property p_conv;
		convert_strobe_o |=> !convert_strobe_o;
	endproperty
	a_conv: assert property (p_conv) else $error("strobe too long");
	property p_window;
		analog_trig_o && $past(cond_reg) < 3'h3 |-> $past(hit);
	endproperty
	a_window: assert property (p_window) else $error("level fire wrong");
	property p_hyst_hi;
		analog_trig_o && $past(cond_reg) == 3'h3 |-> $past(above);
	endproperty
	a_hyst_hi: assert property (p_hyst_hi) else $error("high hysteresis fire wrong");
	property p_hyst_lo;
		analog_trig_o && $past(cond_reg) == 3'h4 |-> $past(below);
	endproperty
	a_hyst_lo: assert property (p_hyst_lo) else $error("low hysteresis fire wrong");
endmodule
bind dttr_router dttr_asserts u_chk (.*);

/* File: tb/tb_top.sv */
// Self-checking bench: random routing runs, corner cases and analog sweeps.
// Assumes the far-side model drives every asynchronous pin of the router.
`timescale 1ns/10ps
module tb_top;
	localparam [87:0] SEQ = 88'h605fa0a18001ff6050b080;
	localparam [7:0]  LO  = 8'h60;
	localparam [7:0]  HI  = 8'ha0;
	reg         sys_clk_i = 1'h0, rst_b_i = 1'h0, sel_load_i = 1'h0;
	reg         adc_trig_falling_i = 1'h0, dac_trig_falling_i = 1'h0;
	reg         sw_adc_trig_i = 1'h0, sw_dac_trig_i = 1'h0, scan_count_start_i = 1'h0;
	reg         conv_count_strobe_i = 1'h0, update_count_strobe_i = 1'h0;
	reg  [7:0]  trig_level_code_i = 8'h80, low_threshold_i = LO, high_threshold_i = HI;
	reg  [2:0]  analog_cond_i = 3'h0;
	reg  [1:0]  tb_sel_i = 2'h0, adc_trig_sel_i = 2'h0, dac_trig_sel_i = 2'h0;
	reg  [1:0]  scan_sel_i = 2'h0, conv_sel_i = 2'h0, update_sel_i = 2'h0;
	reg  [8:0]  fire = 9'h000;
	reg  [31:0] seed = 32'heb872566, r;
	wire [8:0]  pins;
	wire        adc_digital_trig_in_i, dac_digital_trig_in_i, aux_input_zero_i, aux_input_one_i;
	wire        syncbus_adc_trigger_i, syncbus_dac_trigger_i, syncbus_scan_begin_i;
	wire        syncbus_convert_strobe_i, syncbus_dac_update_i, aux_conv_mode_o;
	wire [1:0]  tb_sel_o;
	wire        analog_trig_o, adc_trigger_o, dac_trigger_o, adc_trigger_echo_o;
	wire        dac_trigger_echo_o, scan_start_o, convert_strobe_o, dac_update_strobe_o;
	wire [7:0]  outs = {dac_update_strobe_o, convert_strobe_o, scan_start_o,
		dac_trigger_echo_o, adc_trigger_echo_o, dac_trigger_o, adc_trigger_o, analog_trig_o};
	integer     failures = 0, check_count = 0, k, i, j, m;
	integer     cnt [0:7] = '{default: 0};
	integer     base [0:7];
	assign {syncbus_dac_update_i, syncbus_convert_strobe_i, syncbus_scan_begin_i,
		syncbus_dac_trigger_i, syncbus_adc_trigger_i, aux_input_one_i, aux_input_zero_i,
		dac_digital_trig_in_i, adc_digital_trig_in_i} = pins;
	dttr_router u_dut (.*);
	dttr_far_side u_far (.sys_clk_i(sys_clk_i), .fire_i(fire),
		.idle_i({7'h00, dac_trig_falling_i, adc_trig_falling_i}), .pin_o(pins));
	always #12.5 sys_clk_i = ~sys_clk_i;
	// Tally output pulses; a stuck output shows up as an extra count
	always @(posedge sys_clk_i) begin
		for (m = 0; m < 8; m = m + 1)
			if (outs[m] === 1'h1)
				cnt[m] = cnt[m] + 1;
	end
	// Pulse count per output from the chosen sources; aux conversion masks two
	function [7:0] expect_of(input [1:0] a, d, sc, c, u, input [13:0] f);
		reg ea, ed;
		begin
			ea = a == 2'h0 ? f[9] : a == 2'h1 ? f[0] : a == 2'h3 && f[4];
			ed = d == 2'h0 ? f[10] : d == 2'h1 ? f[1] : d == 2'h3 && f[5];
			expect_of = {u == 2'h1 ? f[3] : u == 2'h2 ? f[8] : f[13],
				c == 2'h1 ? f[2] : c == 2'h2 ? f[7] : f[12],
				c != 2'h1 && (sc == 2'h1 ? f[2] : sc == 2'h2 ? f[6] : f[11]),
				ed, ea, ed, ea && c != 2'h1, 1'h0};
		end
	endfunction
	// Firings over the code sweep; hysteresis counts once per re-arm
	function [7:0] hits(input [2:0] cd);
		integer n;
		reg [7:0] v;
		reg now, was, arm, f;
		begin
			hits = 8'h00;
			was = 1'h0;
			arm = 1'h1;
			for (n = 10; n >= 0; n = n - 1) begin
				v = SEQ[8*n +: 8];
				now = cd == 3'h0 ? v < LO : cd == 3'h1 ? v > HI : v >= LO && v <= HI;
				f = cd == 3'h3 ? v > HI : v < LO;
				if (cd > 3'h2) begin
					hits = hits + (f & arm);
					arm = arm & !f | (cd == 3'h3 ? v < LO : v > HI);
				end else
					hits = hits + (now & !was);
				was = now;
			end
		end
	endfunction
	task step;
		begin
			@(posedge sys_clk_i);
			#2;
		end
	endtask
	task close_out;
		begin
			if (failures == 0 && check_count > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				failures = failures + 1;
				$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task snap;
		for (k = 0; k < 8; k = k + 1)
			base[k] = cnt[k];
	endtask
	task cmp(input [7:0] e, input [7:0] h);
		for (k = 0; k < 8; k = k + 1)
			chk(8'(cnt[k] - base[k]), e[k] ? h : 8'h00);
	endtask
	// Polarity changes with the pin idle level, so no active edge is made
	task load(input [1:0] a, d, sc, c, u);
		begin
			{adc_trig_sel_i, dac_trig_sel_i, scan_sel_i, conv_sel_i, update_sel_i} = {a, d, sc, c, u};
			sel_load_i = 1'h1;
			step;
			sel_load_i = 1'h0;
			r = $random(seed);
			{dac_trig_falling_i, adc_trig_falling_i} = r[1:0];
			repeat (6) step;
		end
	endtask
	task run(input ld, input [1:0] a, d, sc, c, u, input [13:0] f);
		begin
			if (ld)
				load(a, d, sc, c, u);
			snap;
			{update_count_strobe_i, conv_count_strobe_i, scan_count_start_i, sw_dac_trig_i,
				sw_adc_trig_i, fire} = f;
			step;
			{update_count_strobe_i, conv_count_strobe_i, scan_count_start_i, sw_dac_trig_i,
				sw_adc_trig_i, fire} = 14'h0000;
			repeat (10) step;
			cmp(expect_of(a, d, sc, c, u, f), 8'h01);
		end
	endtask
	initial begin
		#(25 * 5000);
		failures = failures + 1;
		close_out;
	end
	initial begin
		repeat (4) step;
		rst_b_i = 1'h1;
		chk({6'h00, tb_sel_o}, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			tb_sel_i = i[1:0];
			load(2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
			chk({6'h00, tb_sel_o}, 8'(i % 3));
		end
		run(1'h1, 2'h3, 2'h3, 2'h2, 2'h1, 2'h2, 14'h3fff);
		run(1'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 14'h3fff);
		run(1'h1, 2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 14'h3fff);
		for (i = 0; i < 40; i = i + 1) begin
			r = $random(seed);
			run(1'h1, r[1:0], r[3:2], r[5:4], r[7:6], r[9:8], r[23:10]);
		end
		tb_sel_i = 2'h2;
		run(1'h1, 2'h3, 2'h1, 2'h1, 2'h1, 2'h1, 14'h0000);
		chk({5'h00, tb_sel_o, aux_conv_mode_o}, 8'h05);
		rst_b_i = 1'h0;
		repeat (4) step;
		rst_b_i = 1'h1;
		chk({5'h00, tb_sel_o, aux_conv_mode_o}, 8'h00);
		run(1'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 14'h3fff);
		for (i = 0; i < 5; i = i + 1) begin
			trig_level_code_i = i == 4 ? 8'hb0 : i > 1 ? 8'h50 : 8'h80;
			repeat (4) step;
			analog_cond_i = i[2:0];
			load(2'h2, 2'h2, 2'h0, 2'h0, 2'h0);
			snap;
			for (j = 10; j >= 0; j = j - 1) begin
				trig_level_code_i = SEQ[8*j +: 8];
				repeat (6) step;
			end
			cmp(8'h1f, hits(i[2:0]));
		end
		close_out;
	end
endmodule
